// ==== logic/pado_core.sv ====
/*
 * Digital side of a pipelined 10-bit converter: sub-clock from both
 * edges of the sample clock pin, per-stage delay lines, redundant-bit
 * error correction, fixed latency, output coding and output disable.
 * Assumes the sample clock pin toggles no faster than core_clk / 8 and
 * that stage codes from the quantizers are stable when a tick is seen.
 */
// Contract
// [R01] Nine pipeline stages, each resolving two bits with quantizer and DAC.
// [R02] Every stage converts on a sub-clock tick at twice sample rate.
// [R03] Each stage result delayed to align, then corrected with redundant bits.
// [R04] Both sample clock edges sequence stages; one new sample per period.
// [R05] Valid output word appears 6.5 sample cycles after its sample.
// [R06] Result is a 10-bit parallel word with no missing codes.
// [R07] Coding select low or open gives straight offset binary.
// [R08] Coding select high gives two's complement by inverting the MSB.
// [R09] Negative full scale gives 0x000 offset binary, 0x200 two's complement.
// [R10] Output-enable low drives outputs; high places them in high impedance.
// [R11] Host keeps output enable static and never shares the data bus.
// [R12] Host supplies a near 50% duty clock, slight skew above 35 MHz.
// [R13] Host latches one word per period, tagged 6.5 cycles back.
`timescale 1ns/1ps
`default_nettype none
module pado_core
	import pado_pkg::*;
#(
	parameter int N_STAGES = STAGES,
	parameter int WORD_W = OUT_W
)
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic sample_clk,
	input wire logic [N_STAGES*STAGE_BITS-1:0] stage_code,
	input wire logic coding_sel,
	input wire logic out_enable_n,
	output logic [WORD_W-1:0] data_out,
	output logic data_oe,
	output logic data_strobe
);
	// Elaboration check: the latency split only works for this shape
	if (N_STAGES != STAGES || WORD_W != OUT_W || POST_TICKS < 1)
	begin : g_bad_shape
		$error("pado_core: unsupported pipeline shape");
	end

	// Pin synchronisers; stage 0 is read by stage 1 only
	// Limitation: a pin level shorter than two core cycles is lost
	logic [SYNC_FF-1:0] clk_sync_q, clk_sync_d;
	logic [SYNC_FF-1:0] cod_sync_q, cod_sync_d;
	logic [SYNC_FF-1:0] oen_sync_q, oen_sync_d;
	logic clk_lvl_q, clk_lvl_d;
	logic cod_lvl_q, cod_lvl_d;
	logic oen_lvl_q, oen_lvl_d;
	logic tick_q, tick_d;
	logic rise_q, rise_d;

	// A change counts once the last two stages agree
	always_comb
	begin
		clk_sync_d = {clk_sync_q[SYNC_FF-2:0], sample_clk};
		cod_sync_d = {cod_sync_q[SYNC_FF-2:0], coding_sel};
		oen_sync_d = {oen_sync_q[SYNC_FF-2:0], out_enable_n};
		clk_lvl_d = clk_lvl_q;
		cod_lvl_d = cod_lvl_q;
		oen_lvl_d = oen_lvl_q;
		if (clk_sync_q[1] == clk_sync_q[2])
		begin
			clk_lvl_d = clk_sync_q[2];
		end
		if (cod_sync_q[1] == cod_sync_q[2])
		begin
			cod_lvl_d = cod_sync_q[2];
		end
		if (oen_sync_q[1] == oen_sync_q[2])
		begin
			oen_lvl_d = oen_sync_q[2];
		end
		// Each edge of the sample clock is one sub-clock tick
		tick_d = (clk_lvl_d != clk_lvl_q); // R02 R04
		rise_d = tick_d && clk_lvl_d; // R04
	end

	// Pins idle low after reset, matching the internal pull-downs
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			clk_sync_q <= '0;
			cod_sync_q <= '0;
			oen_sync_q <= '0;
			clk_lvl_q <= 1'b0;
			cod_lvl_q <= 1'b0;
			oen_lvl_q <= 1'b0;
			tick_q <= 1'b0;
			rise_q <= 1'b0;
		end
		else
		begin
			clk_sync_q <= clk_sync_d;
			cod_sync_q <= cod_sync_d;
			oen_sync_q <= oen_sync_d;
			clk_lvl_q <= clk_lvl_d;
			cod_lvl_q <= cod_lvl_d;
			oen_lvl_q <= oen_lvl_d;
			tick_q <= tick_d;
			rise_q <= rise_d;
		end
	end

	// Aligned stage results, one per stage
	logic [STAGE_BITS-1:0] aligned_w [N_STAGES];

	// Per-stage delay line: stage k captures k ticks after the sample
	// edge and waits N_STAGES-1-k more ticks, so all line up together
	for (genvar k = 0; k < N_STAGES; k++)
	begin : g_stage
		localparam int LEN = N_STAGES - k;
		logic [STAGE_BITS-1:0] line_q [LEN];
		logic [STAGE_BITS-1:0] line_d [LEN];

		always_comb
		begin
			for (int i = 0; i < LEN; i++)
			begin
				line_d[i] = line_q[i];
			end
			if (tick_q)
			begin
				// Stage 0 code sits in the top bits of stage_code
				line_d[0] = stage_code[(N_STAGES-k)*STAGE_BITS-1 -: STAGE_BITS]; // R01 R02
				for (int i = 1; i < LEN; i++)
				begin
					line_d[i] = line_q[i-1]; // R03
				end
			end
		end

		always_ff @(posedge core_clk or negedge nrst)
		begin
			if (!nrst)
			begin
				for (int i = 0; i < LEN; i++)
				begin
					line_q[i] <= '0;
				end
			end
			else
			begin
				line_q <= line_d;
			end
		end

		assign aligned_w[k] = line_q[LEN-1]; // R03
	end

	// Error correction: overlapping two-bit digits, one bit of redundancy
	// per stage; the sum saturates so an over-range never wraps around
	logic [SUM_W-1:0] sum_w;
	logic [WORD_W-1:0] corr_w;
	always_comb
	begin
		sum_w = '0;
		for (int k = 0; k < N_STAGES; k++)
		begin
			sum_w = sum_w + (SUM_W'(aligned_w[k]) << (N_STAGES - 1 - k)); // R03
		end
		if (sum_w > SUM_W'(CODE_MAX))
		begin
			corr_w = CODE_MAX; // R06
		end
		else
		begin
			corr_w = sum_w[WORD_W-1:0]; // R06
		end
	end

	// Word delay line after correction, then the output register
	logic [WORD_W-1:0] post_q [POST_TICKS];
	logic [WORD_W-1:0] post_d [POST_TICKS];
	logic [WORD_W-1:0] data_q, data_d;
	logic oe_q, oe_d;
	logic strobe_q, strobe_d;

	always_comb
	begin
		for (int i = 0; i < POST_TICKS; i++)
		begin
			post_d[i] = post_q[i];
		end
		data_d = data_q;
		strobe_d = 1'b0;
		if (tick_q)
		begin
			post_d[0] = corr_w;
			for (int i = 1; i < POST_TICKS; i++)
			begin
				post_d[i] = post_q[i-1];
			end
			// A sample starts on a rising tick; 13 ticks on is a falling one
			if (!rise_q)
			begin
				strobe_d = 1'b1; // R05
				if (pado_coding_t'(cod_lvl_q) == PADO_TWOS_COMP)
				begin
					data_d = {~post_q[POST_TICKS-1][WORD_W-1],
						post_q[POST_TICKS-1][WORD_W-2:0]}; // R08 R09
				end
				else
				begin
					data_d = post_q[POST_TICKS-1]; // R07 R09
				end
			end
		end
		// Enable is a static test control, so no glitch guard is needed
		oe_d = !oen_lvl_q; // R10
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < POST_TICKS; i++)
			begin
				post_q[i] <= '0;
			end
			data_q <= '0;
			oe_q <= 1'b0;
			strobe_q <= 1'b0;
		end
		else
		begin
			post_q <= post_d;
			data_q <= data_d;
			oe_q <= oe_d;
			strobe_q <= strobe_d;
		end
	end

	assign data_out = data_q;
	assign data_oe = oe_q;
	assign data_strobe = strobe_q;

	// Stage 0 takes the top code on each tick
	stage_cap_a: assert property (@(posedge core_clk) disable iff (!nrst) // R01
		tick_q |=> g_stage[0].line_q[0] == $past(stage_code[N_STAGES*STAGE_BITS-1 -: STAGE_BITS]))
		else $error("stage 0 did not capture its code");

	// Ticks come from real level changes and are isolated pulses
	sub_tick_a: assert property (@(posedge core_clk) disable iff (!nrst) // R02
		tick_q |-> clk_lvl_q != $past(clk_lvl_q, 2) ##1 !tick_q)
		else $error("sub-clock tick without a clock edge");

	// Corrected word enters the word delay on each tick
	align_in_a: assert property (@(posedge core_clk) disable iff (!nrst) // R03
		tick_q |=> post_q[0] == $past(corr_w))
		else $error("corrected word not loaded");

	// Rising ticks only where the synchronised pin went high from low
	both_edge_a: assert property (@(posedge core_clk) disable iff (!nrst) // R04
		rise_q |-> tick_q && $past(clk_sync_q[SYNC_FF-1]) &&
		!$past(clk_lvl_q))
		else $error("sample start on wrong edge");

	// The word stands between strobes; it never changes without one
	word_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) // R05
		!strobe_q |-> $stable(data_q))
		else $error("output word changed without a strobe");

	// Words update only on falling ticks: half a period past the start
	half_cycle_a: assert property (@(posedge core_clk) disable iff (!nrst) // R05
		strobe_q |-> $past(tick_q) && !$past(rise_q))
		else $error("output updated on a rising tick");

	// Over-range clamps to all ones
	saturate_a: assert property (@(posedge core_clk) disable iff (!nrst) // R06
		tick_q && sum_w > SUM_W'(CODE_MAX) |=> post_q[0] == CODE_MAX)
		else $error("over-range word wrapped");

	// Offset binary passes the word unchanged
	offset_code_a: assert property (@(posedge core_clk) disable iff (!nrst) // R07
		strobe_q && !$past(cod_lvl_q) |-> data_q == $past(post_q[POST_TICKS-1]))
		else $error("offset binary word altered");

	// Two's complement inverts only the top bit
	twos_code_a: assert property (@(posedge core_clk) disable iff (!nrst) // R08
		strobe_q && $past(cod_lvl_q) |->
		data_q == ($past(post_q[POST_TICKS-1]) ^ CODE_NEG_FS_TWOS))
		else $error("two's complement word wrong");

	// Negative full scale codes in both formats
	neg_fs_a: assert property (@(posedge core_clk) disable iff (!nrst) // R09
		strobe_q && $past(post_q[POST_TICKS-1]) == CODE_NEG_FS_OFFSET |->
		data_q == ($past(cod_lvl_q) ? CODE_NEG_FS_TWOS : CODE_NEG_FS_OFFSET))
		else $error("negative full scale code wrong");

	// Output drive follows the filtered enable level one cycle later
	out_hiz_a: assert property (@(posedge core_clk) disable iff (!nrst) // R10
		$rose(oen_lvl_q) |=> !data_oe [*2])
		else $error("outputs driven while disabled");
endmodule
`default_nettype wire

// ==== logic/pado_pkg.sv ====
/*
 * Shared constants of the converter's digital output side: pipeline
 * shape, output coding, synchroniser depth and latency figures.
 * Assumes a single core clock and no register bus.
 */
package pado_pkg;
	// Pipeline shape
	localparam int STAGES = 9;
	localparam int STAGE_BITS = 2;
	localparam int OUT_W = 10;
	localparam int SUM_W = OUT_W + 2;
	// Sample-to-output latency in sample-clock half cycles (6.5 cycles)
	localparam int LAT_HALF_CYCLES = 13;
	// Word delay after correction, in sub-clock ticks
	localparam int POST_TICKS = LAT_HALF_CYCLES - STAGES;
	// Pin synchroniser depth
	localparam int SYNC_FF = 3;
	// Codes at the ends of the range
	localparam logic [OUT_W-1:0] CODE_MAX = 10'h3ff;
	localparam logic [OUT_W-1:0] CODE_NEG_FS_OFFSET = 10'h000;
	localparam logic [OUT_W-1:0] CODE_NEG_FS_TWOS = 10'h200;
	// Coding select levels
	typedef enum logic {PADO_OFFSET_BIN, PADO_TWOS_COMP} pado_coding_t;
endpackage

// ==== testbench/pado_host_model.sv ====
/*
 * Host-side capture model: makes the sample clock and latches each word.
 * Assumes the core clock is free running and HALF is at least 4 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module pado_host_model
	import pado_pkg::*;
#(
	parameter int HALF = 8
)
(
	input wire logic core_clk,
	input wire logic run,
	input wire logic [OUT_W-1:0] data_out,
	input wire logic data_oe,
	input wire logic data_strobe,
	output logic sample_clk,
	output wire logic [OUT_W-1:0] bus,
	output logic [OUT_W-1:0] word,
	output int words
);
	int cnt;
	// Released pins float, so the resolved bus shows Z, not a stale word
	assign bus = data_oe ? data_out : 10'hzzz;
	// Square clock, 50% duty; it stands still while run is low
	initial
	begin
		sample_clk = 1'b0;
		cnt = 0;
		words = 0;
		word = 10'h000;
	end
	always @(negedge core_clk)
	begin
		if (run)
		begin
			cnt = cnt + 1;
			if (cnt >= HALF)
			begin
				cnt = 0;
				sample_clk = ~sample_clk;
			end
		end
	end
	// One word per strobe, taken from the resolved bus
	always @(posedge core_clk)
	begin
		if (data_strobe)
		begin
			word <= bus;
			words <= words + 1;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/tb_pipelined_adc_output_interface.sv ====
/*
 * Self-checking bench for the converter output side.
 * Assumes the host model above and a 25 MHz core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_pipelined_adc_output_interface;
	import pado_pkg::*;
	localparam int HALF = 8;
	logic core_clk, nrst, coding_sel, out_enable_n, run;
	logic [STAGES*STAGE_BITS-1:0] stage_code;
	logic [OUT_W-1:0] data_out, word;
	wire logic [OUT_W-1:0] bus;
	logic data_oe, data_strobe, sample_clk;
	int words, num_errors, n_tests;
	pado_core DUT (.core_clk(core_clk), .nrst(nrst), .sample_clk(sample_clk),
		.stage_code(stage_code), .coding_sel(coding_sel), .out_enable_n(out_enable_n),
		.data_out(data_out), .data_oe(data_oe), .data_strobe(data_strobe));
	pado_host_model #(.HALF(HALF)) host (.core_clk(core_clk), .run(run),
		.data_out(data_out), .data_oe(data_oe), .data_strobe(data_strobe),
		.sample_clk(sample_clk), .bus(bus), .word(word), .words(words));
	// 40 ns core clock
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic summarize();
		$display("errors %0d, comparisons %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp_word(input logic [OUT_W-1:0] got, input logic [OUT_W-1:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_num(input int got, input int exp);
		n_tests++;
		if (got != exp)
		begin
			num_errors++;
			$display("mismatch at %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask
	// Bounded wait for n more captured words
	task automatic wait_words(input int n);
		int t;
		t = words + n;
		for (int i = 0; i < n * 4 * HALF && words < t; i++)
		begin
			@(posedge core_clk);
			#1;
		end
		if (words < t)
		begin
			num_errors++;
			$display("mismatch at %0t: no word within bound", $time);
			summarize();
		end
	endtask
	// Ends of range and one step up, in both codings
	task automatic t_codes();
		logic [STAGES*STAGE_BITS-1:0] codes [3] = '{18'h00000, 18'h00001, 18'h3ffff};
		logic [OUT_W-1:0] exps [3] = '{10'h000, 10'h001, 10'h3ff};
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 3; i++)
			begin
				@(negedge core_clk);
				coding_sel = c[0];
				stage_code = codes[i];
				wait_words(10);
				cmp_word(word, exps[i] ^ (c[0] ? 10'h200 : 10'h000));
			end
		coding_sel = 1'b0;
	endtask
	// Full word appears on the seventh strobe after its rising clock
	task automatic t_latency();
		@(negedge core_clk);
		stage_code = 18'h00000;
		wait_words(10);
		@(posedge sample_clk);
		stage_code = 18'h3ffff;
		wait_words(6);
		cmp_word(word, 10'h17d);
		wait_words(1);
		cmp_word(word, 10'h3ff);
	endtask
	// One word per sample period
	task automatic t_period();
		realtime t0;
		wait_words(1);
		t0 = $realtime;
		wait_words(1);
		cmp_num(int'(($realtime - t0) / 40.0), 2 * HALF);
	endtask
	// Disable floats the bus; enable drives it again
	// Conversion is halted first: enable is only a static test control
	task automatic t_disable();
		@(negedge core_clk);
		run = 1'b0;
		repeat (4) @(negedge core_clk);
		out_enable_n = 1'b1;
		repeat (8) @(negedge core_clk);
		cmp_word(bus, 10'hzzz);
		out_enable_n = 1'b0;
		repeat (8) @(negedge core_clk);
		cmp_word({9'h000, data_oe}, 10'h001);
		run = 1'b1;
		wait_words(2);
		cmp_word(bus, 10'h3ff);
	endtask
	initial
	begin
		nrst = 1'b0;
		run = 1'b0;
		coding_sel = 1'b0;
		out_enable_n = 1'b0;
		stage_code = 18'h00000;
		num_errors = 0;
		n_tests = 0;
		repeat (16) @(negedge core_clk);
		nrst = 1'b1;
		run = 1'b1;
		t_codes();
		t_latency();
		t_period();
		t_disable();
		summarize();
	end
endmodule
`default_nettype wire
